// [include/rx_los_pkg.sv]
package rx_los_pkg;
    typedef enum logic [1:0] {
        MODE_DS3 = 2'h0,
        MODE_E3 = 2'h1,
        MODE_STS1 = 2'h2
    } line_mode_e;

    typedef enum logic [1:0] {
        LOS_CLEAR = 2'h0,
        LOS_DECLARED = 2'h1
    } los_state_e;

    localparam int ZERO_CNT_W = 8;
    localparam logic [7:0] LOS_DECLARE_ZEROS = 8'hc0;
    localparam logic [7:0] LOS_CLEAR_BITS = 8'hc0;
    localparam logic [7:0] EXZ_RUN_DS3 = 8'h03;
    localparam logic [7:0] EXZ_RUN_E3 = 8'h04;
    localparam int LOCK_SET_PPM = 7900;
    localparam int LOCK_CLR_PPM = 7700;
    localparam int PPM_SCALE = 1000000;
    localparam int GAIN_W = 8;
    localparam int TERM_ADJ_W = 4;
endpackage

// [core/change_irq.sv]
module change_irq (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic level,
    input wire logic enable,
    output logic irq
);
    logic prev_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level;
        end
    end

    assign irq = enable & (level ^ prev_reg);
endmodule

// [core/rx_signal_loss_monitor.sv]
// What this block does
// - Declare loss after 192 consecutive zero bits out of data recovery.
// - Clear loss after 192 recovered bit periods with no excess-zero run.
// - Excess-zero run is three zeros in DS3/STS-1, four zeros in E3.
// - Loss status bit follows loss; loss pin too in hardware mode.
// - Each loss status change raises an interrupt request when enabled.
// - Loss is declared only while the zero-substitution decoder is enabled.
// - Lock lost set above 7900ppm offset, cleared below 7700ppm offset.
// - Lock lost is never set while the reference clock is absent.
// - Each lock lost status change raises an interrupt request when enabled.
// - Analog signal loss forces all-zero recovered data.
// - Analog loss mirrored in a status bit; changes interrupt when enabled.
// - During loss the receive clock comes from the reference clock.
// - Enabled preamp decides its gain itself and reports it in a status bit.
// - Each preamp-active change raises an interrupt request when enabled.
// - Termination only via its control bit in processor mode; 4-bit adjust.
// - Current receiver gain level is readable and tracks in real time.
// - Recovery and lock monitoring are timed from the reference clock.
module rx_signal_loss_monitor #(
    parameter int LOCK_WINDOW = 65536,
    parameter int EXPECTED_BITS = 14660,
    parameter int REF_BIT_DIV = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rec_bit_valid,
    input wire logic rec_pulse,
    input wire rx_los_pkg::line_mode_e line_mode,
    input wire logic zero_subst_decode_disable,
    input wire logic hw_mode,
    input wire logic analog_signal_loss,
    input wire logic ref_clk_present,
    input wire logic monitor_preamp_enable_pin,
    input wire logic monitor_preamp_enable,
    input wire logic preamp_gain_wanted,
    input wire logic rx_internal_term_enable,
    input wire logic [rx_los_pkg::TERM_ADJ_W-1:0] rx_term_resistor_adjust,
    input wire logic [rx_los_pkg::GAIN_W-1:0] gain_level_in,
    input wire logic rx_loss_irq_enable,
    input wire logic lock_lost_irq_enable,
    input wire logic analog_loss_irq_enable,
    input wire logic preamp_active_irq_enable,
    output logic rx_loss_indication,
    output logic rx_loss_pin,
    output logic rx_lock_lost,
    output logic analog_loss_status,
    output logic preamp_active_status,
    output logic irq_request,
    output logic rx_data_out,
    output logic rx_bit_strobe_out,
    output logic rx_clk_from_ref,
    output logic rx_term_enable,
    output logic [rx_los_pkg::TERM_ADJ_W-1:0] rx_term_adjust,
    output logic [rx_los_pkg::GAIN_W-1:0] rx_gain_level
);
    import rx_los_pkg::*;

    localparam int WIN_W = $clog2(LOCK_WINDOW + 1);
    // Sized for a bit on every cycle, so a runaway clock cannot wrap it.
    localparam int CNT_W = $clog2(LOCK_WINDOW + EXPECTED_BITS + 1);
    localparam int DIV_W = $clog2(REF_BIT_DIV + 1);
    localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(LOCK_WINDOW - 1);
    localparam logic [CNT_W-1:0] EXP_CNT = CNT_W'(EXPECTED_BITS);
    localparam logic [CNT_W-1:0] SET_TH =
        CNT_W'(EXPECTED_BITS * LOCK_SET_PPM / PPM_SCALE);
    localparam logic [CNT_W-1:0] CLR_TH =
        CNT_W'((EXPECTED_BITS * LOCK_CLR_PPM + PPM_SCALE - 1) / PPM_SCALE);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(REF_BIT_DIV - 1);

    los_state_e los_reg;
    los_state_e los_next;
    logic [ZERO_CNT_W-1:0] zero_cnt_reg;
    logic [ZERO_CNT_W-1:0] zero_cnt_next;
    logic [ZERO_CNT_W-1:0] clear_cnt_reg;
    logic [ZERO_CNT_W-1:0] clear_cnt_next;
    logic [WIN_W-1:0] win_cnt_reg;
    logic [CNT_W-1:0] bit_cnt_reg;
    logic lock_lost_reg;
    logic lock_lost_next;
    logic [DIV_W-1:0] div_cnt_reg;
    logic ref_strobe_reg;
    logic data_reg;
    logic strobe_reg;
    logic [GAIN_W-1:0] gain_reg;

    // Muting the data feeds the digital detector, so loss follows.
    wire data_bit = rec_pulse & ~analog_signal_loss;
    wire [ZERO_CNT_W-1:0] exz_run =
        (line_mode == MODE_E3) ? EXZ_RUN_E3 : EXZ_RUN_DS3;
    wire zero_sat = (zero_cnt_reg == LOS_DECLARE_ZEROS);
    // Every zero beyond the run length is still part of the occurrence.
    wire exz_hit = rec_bit_valid & ~data_bit &
        (zero_cnt_next >= exz_run);
    wire los_set = rec_bit_valid & ~zero_subst_decode_disable &
        (zero_cnt_next == LOS_DECLARE_ZEROS);
    wire los_clr = rec_bit_valid & (clear_cnt_next == LOS_CLEAR_BITS);
    wire los_now = (los_reg == LOS_DECLARED);
    wire win_end = (win_cnt_reg == WIN_LAST);
    wire [CNT_W-1:0] bit_cnt_inc = bit_cnt_reg + CNT_W'(rec_bit_valid);
    wire [CNT_W-1:0] freq_diff = (bit_cnt_inc > EXP_CNT) ?
        (bit_cnt_inc - EXP_CNT) : (EXP_CNT - bit_cnt_inc);
    wire lock_set = win_end & ref_clk_present & (freq_diff > SET_TH);
    wire lock_clr = win_end & (freq_diff < CLR_TH);
    wire preamp_on = monitor_preamp_enable_pin | monitor_preamp_enable;
    wire irq_los;
    wire irq_lock;
    wire irq_analog_signal_loss;
    wire irq_preamp;

    // Counter restarts on a pulse and holds at the threshold.
    assign zero_cnt_next = data_bit ? '0 :
        (zero_sat ? zero_cnt_reg : zero_cnt_reg + 8'h01);
    // Span restarts at each excess-zero run while loss stands.
    assign clear_cnt_next = (exz_hit || !los_now) ? '0 :
        ((clear_cnt_reg == LOS_CLEAR_BITS) ? clear_cnt_reg :
        clear_cnt_reg + 8'h01);

    always_comb begin
        los_next = los_reg;
        case (los_reg)
            LOS_CLEAR: begin
                if (los_set) begin
                    los_next = LOS_DECLARED;
                end
            end
            LOS_DECLARED: begin
                if (zero_subst_decode_disable) begin
                    los_next = LOS_CLEAR;
                end else if (los_clr && !los_set) begin
                    los_next = LOS_CLEAR;
                end
            end
            default: begin
                los_next = LOS_CLEAR;
            end
        endcase
    end

    // Set has priority, and an absent reference blocks only the set.
    assign lock_lost_next = lock_set ? 1'b1 :
        (lock_clr ? 1'b0 : lock_lost_reg);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            los_reg <= LOS_CLEAR;
            zero_cnt_reg <= '0;
            clear_cnt_reg <= '0;
        end else begin
            los_reg <= los_next;
            if (rec_bit_valid) begin
                zero_cnt_reg <= zero_cnt_next;
                clear_cnt_reg <= clear_cnt_next;
            end
        end
    end

    // Frequency is measured in reference clock windows.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            win_cnt_reg <= '0;
            bit_cnt_reg <= '0;
            lock_lost_reg <= 1'b0;
        end else begin
            win_cnt_reg <= win_end ? '0 : win_cnt_reg + WIN_W'(1);
            bit_cnt_reg <= win_end ? '0 : bit_cnt_inc;
            lock_lost_reg <= lock_lost_next;
        end
    end

    // The reference bit strobe stands in for the recovered clock.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_cnt_reg <= '0;
            ref_strobe_reg <= 1'b0;
            data_reg <= 1'b0;
            strobe_reg <= 1'b0;
            gain_reg <= '0;
        end else begin
            div_cnt_reg <= (div_cnt_reg == DIV_LAST) ?
                '0 : div_cnt_reg + DIV_W'(1);
            ref_strobe_reg <= (div_cnt_reg == DIV_LAST);
            data_reg <= rec_bit_valid ? data_bit : data_reg;
            strobe_reg <= los_now ? ref_strobe_reg : rec_bit_valid;
            gain_reg <= gain_level_in;
        end
    end

    change_irq u_irq_los (
        .core_clk(core_clk),
        .rst(rst),
        .level(los_now),
        .enable(rx_loss_irq_enable),
        .irq(irq_los)
    );
    change_irq u_irq_lock (
        .core_clk(core_clk),
        .rst(rst),
        .level(lock_lost_reg),
        .enable(lock_lost_irq_enable),
        .irq(irq_lock)
    );
    change_irq u_irq_analog_signal_loss (
        .core_clk(core_clk),
        .rst(rst),
        .level(analog_signal_loss),
        .enable(analog_loss_irq_enable),
        .irq(irq_analog_signal_loss)
    );
    change_irq u_irq_preamp (
        .core_clk(core_clk),
        .rst(rst),
        .level(preamp_active_status),
        .enable(preamp_active_irq_enable),
        .irq(irq_preamp)
    );

    assign irq_request =
        irq_los | irq_lock | irq_analog_signal_loss | irq_preamp;
    assign rx_loss_indication = los_now;
    assign rx_loss_pin = los_now & hw_mode;
    assign rx_lock_lost = lock_lost_reg;
    assign analog_loss_status = analog_signal_loss;
    assign preamp_active_status = preamp_on & preamp_gain_wanted;
    assign rx_data_out = data_reg;
    assign rx_bit_strobe_out = strobe_reg;
    assign rx_clk_from_ref = los_now;
    // Hardware mode has no way to set the control bit, so it never terminates.
    assign rx_term_enable = rx_internal_term_enable & ~hw_mode;
    assign rx_term_adjust =
        rx_term_enable ? rx_term_resistor_adjust : '0;
    assign rx_gain_level = gain_reg;

    property p_declare;
        @(posedge core_clk) disable iff (rst)
        (!los_now && los_set) |=> los_now;
    endproperty
    a_declare: assert property (p_declare)
        else $error("loss not declared after zero run");

    property p_no_early_declare;
        @(posedge core_clk) disable iff (rst)
        (!los_now && zero_cnt_reg < 8'hbf) |=> !los_now;
    endproperty
    a_no_early_declare: assert property (p_no_early_declare)
        else $error("loss declared before zero run ended");

    property p_clear;
        @(posedge core_clk) disable iff (rst)
        $fell(los_now) |-> ($past(clear_cnt_next) == LOS_CLEAR_BITS ||
            $past(zero_subst_decode_disable));
    endproperty
    a_clear: assert property (p_clear)
        else $error("loss cleared without a clean span");

    property p_exz_restart;
        @(posedge core_clk) disable iff (rst)
        (los_now && exz_hit) |=> (clear_cnt_reg == 8'h00);
    endproperty
    a_exz_restart: assert property (p_exz_restart)
        else $error("clear span not restarted by excess zeros");

    property p_pin;
        @(posedge core_clk) disable iff (rst)
        rx_loss_pin == (rx_loss_indication && hw_mode);
    endproperty
    a_pin: assert property (p_pin)
        else $error("loss pin disagrees with status");

    property p_irq_los;
        @(posedge core_clk) disable iff (rst)
        ($changed(los_now) && rx_loss_irq_enable) |-> irq_request;
    endproperty
    a_irq_los: assert property (p_irq_los)
        else $error("loss change gave no interrupt");

    property p_decode_off;
        @(posedge core_clk) disable iff (rst)
        zero_subst_decode_disable |=> !los_now;
    endproperty
    a_decode_off: assert property (p_decode_off)
        else $error("loss declared with decoder disabled");

    property p_lock_ref;
        @(posedge core_clk) disable iff (rst)
        (!ref_clk_present && !lock_lost_reg) |=> !lock_lost_reg;
    endproperty
    a_lock_ref: assert property (p_lock_ref)
        else $error("lock lost set without reference");

    property p_mute;
        @(posedge core_clk) disable iff (rst)
        (analog_signal_loss && rec_bit_valid) |=> !rx_data_out;
    endproperty
    a_mute: assert property (p_mute)
        else $error("data not muted during analog loss");

    property p_sat;
        @(posedge core_clk) disable iff (rst)
        zero_cnt_reg <= LOS_DECLARE_ZEROS;
    endproperty
    a_sat: assert property (p_sat)
        else $error("zero counter passed its threshold");

    c_declare: cover property (@(posedge core_clk) $rose(los_now));
    c_clear: cover property (@(posedge core_clk) $fell(los_now));
    c_lock: cover property (@(posedge core_clk) $rose(lock_lost_reg));
    c_irq: cover property (@(posedge core_clk) irq_request);
endmodule

// [tb/line_source.sv]
module line_source (
    input wire logic core_clk,
    output logic rec_bit_valid,
    output logic rec_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    int left = 0;
    logic [7:0] gap = 8'h00;
    logic [7:0] phase = 8'h00;
    initial begin
        rec_bit_valid = 1'b0;
        rec_pulse = 1'b0;
    end
    // A mark is followed by gap zeros; a gap of ff is a dead line.
    always @(negedge core_clk) begin
        if (left > 0) begin
            rec_bit_valid <= 1'b1;
            rec_pulse <= (phase == 8'h00) && (gap != 8'hff);
            phase <= (phase == gap) ? 8'h00 : phase + 8'h01;
            left <= left - 1;
        end else begin
            rec_bit_valid <= 1'b0;
            // The mark line is junk between bits, so it must not look idle.
            rec_pulse <= ~rec_pulse;
        end
    end
endmodule

// [tb/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rx_los_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic hw_mode = 1'b1;
    line_mode_e line_mode = MODE_DS3;
    logic zsd = 1'b0;
    logic analog_signal_loss = 1'b0;
    logic ref_clk_present = 1'b1;
    logic pre_pin = 1'b0, pre_bit = 1'b0, wanted = 1'b0, term_en = 1'b0;
    logic [3:0] term_adj = 4'h5;
    logic [3:0] irq_en = 4'h0;
    logic [7:0] gain_in = 8'h00;
    logic [7:0] lim;
    logic rec_bit_valid, rec_pulse, rx_loss_indication, rx_loss_pin;
    logic rx_lock_lost, analog_loss_status, preamp_active_status;
    logic irq_request, rx_data_out, rx_clk_from_ref, rx_term_enable;
    logic rx_bit_strobe_out;
    logic [3:0] rx_term_adjust;
    logic [7:0] rx_gain_level;
    int num_errors = 0, checks = 0, irqs = 0, cycles = 0, base = 0;

    line_source src (.core_clk, .rec_bit_valid, .rec_pulse);
    // Short lock window; four missing bits still sit inside its tolerance.
    rx_signal_loss_monitor #(.LOCK_WINDOW(512), .EXPECTED_BITS(512),
        .REF_BIT_DIV(4)) dut_u (
        .core_clk, .rst, .rec_bit_valid, .rec_pulse, .line_mode,
        .zero_subst_decode_disable(zsd), .hw_mode, .analog_signal_loss,
        .ref_clk_present, .monitor_preamp_enable_pin(pre_pin),
        .monitor_preamp_enable(pre_bit), .preamp_gain_wanted(wanted),
        .rx_internal_term_enable(term_en), .rx_term_resistor_adjust(term_adj),
        .gain_level_in(gain_in), .rx_loss_irq_enable(irq_en[0]),
        .lock_lost_irq_enable(irq_en[1]), .analog_loss_irq_enable(irq_en[2]),
        .preamp_active_irq_enable(irq_en[3]), .rx_loss_indication,
        .rx_loss_pin, .rx_lock_lost, .analog_loss_status,
        .preamp_active_status, .irq_request, .rx_data_out,
        .rx_bit_strobe_out, .rx_clk_from_ref, .rx_term_enable,
        .rx_term_adjust, .rx_gain_level);

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic conclude();
        if (num_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (irq_request === 1'b1) irqs <= irqs + 1;
        if (cycles >= 20000) begin
            num_errors = num_errors + 1;
            conclude();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic send(input int n, input logic [7:0] g);
        @(posedge core_clk);
        src.gap = g;
        src.phase = 8'h00;
        src.left = n;
        while (src.left != 0) @(negedge core_clk);
        repeat (4) @(negedge core_clk);
    endtask

    task automatic strobes(input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        repeat (8) begin
            @(negedge core_clk);
            n = n + 8'(rx_bit_strobe_out);
        end
        check(n, exp);
    endtask

    task automatic t_declare();
        irq_en = 4'h1;
        base = irqs;
        send(191, 8'hff);
        check(rx_loss_indication, 1'b0);
        send(1, 8'h00);
        send(191, 8'hff);
        check(rx_loss_indication, 1'b0);
        send(1, 8'hff);
        check(rx_loss_indication, 1'b1);
        check(rx_loss_pin, 1'b1);
        check(rx_clk_from_ref, 1'b1);
        check(8'(irqs - base), 8'h01);
        strobes(8'h02);
        hw_mode = 1'b0;
        @(negedge core_clk);
        check(rx_loss_pin, 1'b0);
    endtask

    task automatic t_decode();
        zsd = 1'b1;
        repeat (2) @(negedge core_clk);
        check(rx_loss_indication, 1'b0);
        send(300, 8'hff);
        check(rx_loss_indication, 1'b0);
        zsd = 1'b0;
    endtask

    task automatic t_modes();
        base = irqs;
        for (int m = 0; m < 3; m++) begin
            line_mode = line_mode_e'(m);
            lim = (m == 1) ? EXZ_RUN_E3 : EXZ_RUN_DS3;
            send(192, 8'hff);
            check(rx_loss_indication, 1'b1);
            send(300, lim);
            check(rx_loss_indication, 1'b1);
            send(191, lim - 8'h01);
            check(rx_loss_indication, 1'b1);
            send(1, lim - 8'h01);
            check(rx_loss_indication, 1'b0);
            check(rx_clk_from_ref, 1'b0);
            strobes(8'h00);
        end
        check(8'(irqs - base), 8'h06);
    endtask

    task automatic t_analog();
        irq_en = 4'h4;
        base = irqs;
        analog_signal_loss = 1'b1;
        @(negedge core_clk);
        check(analog_loss_status, 1'b1);
        send(200, 8'h00);
        check(rx_data_out, 1'b0);
        check(rx_loss_indication, 1'b1);
        analog_signal_loss = 1'b0;
        send(200, 8'h00);
        check(rx_data_out, 1'b1);
        check(rx_loss_indication, 1'b0);
        check(analog_loss_status, 1'b0);
        check(8'(irqs - base), 8'h02);
    endtask

    task automatic t_preamp();
        irq_en = 4'h8;
        base = irqs;
        for (int i = 0; i < 8; i++) begin
            {pre_pin, pre_bit, wanted} = 3'(i);
            @(negedge core_clk);
            check(preamp_active_status, (pre_pin | pre_bit) & wanted);
        end
        check(8'(irqs - base), 8'h05);
    endtask

    task automatic t_lock();
        irq_en = 4'h2;
        send(1100, 8'h00);
        check(rx_lock_lost, 1'b0);
        base = irqs;
        ref_clk_present = 1'b0;
        repeat (1100) @(negedge core_clk);
        check(rx_lock_lost, 1'b0);
        ref_clk_present = 1'b1;
        repeat (1100) @(negedge core_clk);
        check(rx_lock_lost, 1'b1);
        send(1100, 8'h00);
        check(rx_lock_lost, 1'b0);
        check(8'(irqs - base), 8'h02);
    endtask

    task automatic t_misc();
        for (int i = 0; i < 4; i++) begin
            {hw_mode, term_en} = 2'(i);
            gain_in = 8'h31 + 8'(i);
            term_adj = 4'h9 + 4'(i);
            repeat (2) @(negedge core_clk);
            check(rx_term_enable, term_en & ~hw_mode);
            check(rx_term_adjust, (i == 1) ? term_adj : 4'h0);
            check(rx_gain_level, gain_in);
        end
    endtask

    initial begin
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        t_declare();
        t_decode();
        t_modes();
        t_analog();
        t_preamp();
        t_lock();
        t_misc();
        conclude();
    end
endmodule
